// File: logic/ssm_ctrl.sv
// Serial controller in SPI-master and I2C-master modes with its register file.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps

// Notes on behaviour
// RULE_01 - Serial rate is 24 MHz over 2*(linear+1)*2^exponent, exponent in bits 3:0.
// RULE_02 - Linear divider factor is a 4-bit field in bits 3:0.
// RULE_03 - Function select: 0 off, 1 UART, 2 SPI, 3 I2C; disable before switching. No UART is built here; mode 1 leaves both engines idle.
// RULE_04 - Receiver-paced clear: start on transmit data; set: start on receive room.
// RULE_05 - Software always sets the role bit to master; slave is invalid.
// RULE_06 - Transmit underrun sends 0xFF, or repeats the last byte when repeat is set.
// RULE_07 - Bit order select clear shifts MSB first, set shifts LSB first.
// RULE_08 - Polarity picks leading edge direction; phase picks leading or second edge sampling.
// RULE_09 - Transmitter idle flag only when transmit FIFO empty and nothing shifting.
// RULE_10 - Transmit space flag whenever the transmit FIFO can take a byte.
// RULE_11 - Receive valid flag whenever the receive FIFO holds a byte.
// RULE_12 - Receive overrun flag sets on overflow, clears on a data port read.
// RULE_13 - Stop command bit makes a STOP and clears itself when done.
// RULE_14 - Start command bit makes a START or repeated START, then clears itself.
// RULE_15 - Send command bit shifts one byte out, then clears itself.
// RULE_16 - Receive command bit clocks one byte in, then clears itself.
// RULE_17 - Acknowledge select set answers each received byte with ACK.
// RULE_18 - Acknowledge select clear answers each received byte with NACK.
// RULE_19 - Separate I2C done, received, sent and NACK flags, cleared at next bus activity.
module ssm_ctrl #(
  parameter int DEPTH = 4
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [15:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [15:0] rdata,
  output logic             irq,
  output logic             spi_sck,
  output logic             spi_mosi,
  input  wire logic        spi_miso,
  input  wire logic        i2c_scl_in,
  output logic             i2c_scl_out,
  output logic             i2c_scl_oe_n,
  input  wire logic        i2c_sda_in,
  output logic             i2c_sda_out,
  output logic             i2c_sda_oe_n
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam int IRQ_W = ssm_pkg::IRQ_W;

  typedef struct packed {
    logic [1:0]            mode;
    logic [3:0]            lin;
    logic [3:0]            expo;
    logic [5:0]            cfg;
    logic [3:0]            cmd;
    logic                  ack;
    logic [3:0]            i2st;
    logic [IRQ_W-1:0]      irq_st;
    logic [IRQ_W-1:0]      irq_mask;
    logic [DEPTH-1:0][7:0] txq;
    logic [PW-1:0]         txwr;
    logic [PW-1:0]         txrd;
    logic [CW-1:0]         txcnt;
    logic [DEPTH-1:0][7:0] rxq;
    logic [PW-1:0]         rxwr;
    logic [PW-1:0]         rxrd;
    logic [CW-1:0]         rxcnt;
    logic                  ovf;
    logic [6:0]            acc;
    logic [19:0]           tcnt;
    ssm_pkg::ssm_spi_t     sst;
    logic [3:0]            h;
    logic [7:0]            sh;
    logic [7:0]            rsh;
    logic [7:0]            last;
    logic                  sck;
    logic                  mosi;
    ssm_pkg::ssm_i2c_t     i2s;
    logic [1:0]            ph;
    logic [3:0]            slot;
    logic                  xmit;
    logic                  nak_smp;
    logic                  scl_oe_n;
    logic                  sda_oe_n;
    logic                  od_zero;
    logic [15:0]           rdata;
    logic                  irq;
  } ssm_state_t;

  ssm_state_t s_r;
  ssm_state_t s_nxt;

  function automatic logic obit(input logic [7:0] b, input logic lsb);
    return lsb ? b[0] : b[7];
  endfunction

  function automatic logic [7:0] shf(input logic [7:0] b, input logic lsb);
    return lsb ? {1'b0, b[7:1]} : {b[6:0], 1'b0};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  logic        tx_empty;
  logic        tx_full;
  logic        rx_empty;
  logic        rx_full;
  logic        wr_data;
  logic        rd_data;
  logic        busy;
  logic        tick;
  logic        unit;
  logic        tx_idle;
  logic        lsb;
  logic        pha;
  logic [7:0]  rx_in;
  logic [19:0] half;

  assign tx_empty = s_r.txcnt == '0;
  assign tx_full  = s_r.txcnt == FULL;
  assign rx_empty = s_r.rxcnt == '0;
  assign rx_full  = s_r.rxcnt == FULL;
  assign wr_data  = wr_en && addr == ssm_pkg::DATA_OFS;
  assign rd_data  = rd_en && addr == ssm_pkg::DATA_OFS;
  assign busy     = s_r.sst == ssm_pkg::SP_RUN || s_r.i2s != ssm_pkg::I2_IDLE;
  assign tx_idle  = tx_empty && s_r.sst == ssm_pkg::SP_IDLE; // RULE_09
  assign lsb      = s_r.cfg[ssm_pkg::CFG_ORD];
  assign pha      = s_r.cfg[ssm_pkg::CFG_PHA];
  // One reference tick per 24 MHz period on average, from the 100 MHz clock.
  assign tick = 7'(s_r.acc + ssm_pkg::REF_INC) >= ssm_pkg::REF_MOD; // RULE_01
  // Half a serial clock period is (linear+1)*2^exponent reference ticks.
  assign half = 20'(5'({1'b0, s_r.lin} + 5'h01)) << s_r.expo; // RULE_01 RULE_02
  assign unit = busy && tick && s_r.tcnt == half - 20'h00001;
  assign rx_in = lsb ? {spi_miso, s_r.rsh[7:1]} : {s_r.rsh[6:0], spi_miso}; // RULE_07

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic             tx_pop;
    logic             tx_push;
    logic             rx_push;
    logic             rx_pop;
    logic [7:0]       rx_byte;
    logic [7:0]       ld;
    logic [15:0]      rv;
    logic [IRQ_W-1:0] ev;
    logic             adv;
    tx_pop  = 1'b0;
    tx_push = wr_data && !tx_full;
    rx_push = 1'b0;
    rx_pop  = rd_data && !rx_empty;
    rx_byte = 8'h00;
    ld      = tx_empty ? ssm_pkg::BUSY_TOKEN : s_r.txq[s_r.txrd];
    rv      = ssm_pkg::REG_RESET;
    ev      = '0;
    adv     = 1'b0;
    s_nxt   = s_r;

    s_nxt.acc = tick ? 7'(s_r.acc + ssm_pkg::REF_INC - ssm_pkg::REF_MOD)
                     : 7'(s_r.acc + ssm_pkg::REF_INC);
    if (busy && tick) begin
      s_nxt.tcnt = unit ? 20'h00000 : s_r.tcnt + 20'h00001;
    end

    // SPI master engine, active only in SPI mode.
    if (s_r.mode != ssm_pkg::MODE_SPI) begin // RULE_03
      s_nxt.sst = ssm_pkg::SP_IDLE;
      s_nxt.sck = s_r.cfg[ssm_pkg::CFG_POL];
    end else begin
      unique case (s_r.sst)
        ssm_pkg::SP_IDLE: begin
          s_nxt.sck = s_r.cfg[ssm_pkg::CFG_POL]; // RULE_08
          if (s_r.cfg[ssm_pkg::CFG_RXPACED] ? !rx_full : !tx_empty) begin // RULE_04
            if (tx_empty && s_r.cfg[ssm_pkg::CFG_RPT]) begin
              ld = s_r.last; // RULE_06
            end
            tx_pop      = !tx_empty;
            s_nxt.last  = ld;
            s_nxt.h     = 4'h0;
            s_nxt.tcnt  = 20'h00000;
            s_nxt.sst   = ssm_pkg::SP_RUN;
            s_nxt.sh    = pha ? ld : shf(ld, lsb);
            if (!pha) begin
              s_nxt.mosi = obit(ld, lsb); // RULE_07
            end
          end
        end
        ssm_pkg::SP_RUN: begin
          if (unit) begin
            s_nxt.sck = !s_r.sck;
            s_nxt.h   = s_r.h + 4'h1;
            // Even half periods end in the leading edge, odd ones in the trailing edge.
            if (s_r.h[0] == pha) begin // RULE_08
              s_nxt.rsh = rx_in;
            end else if (!(s_r.h == ssm_pkg::LAST_HALF && !pha)) begin
              s_nxt.mosi = obit(s_r.sh, lsb);
              s_nxt.sh   = shf(s_r.sh, lsb);
            end
            if (s_r.h == ssm_pkg::LAST_HALF) begin
              s_nxt.sst = ssm_pkg::SP_IDLE;
              rx_push   = 1'b1;
              rx_byte   = pha ? rx_in : s_r.rsh;
              ev[ssm_pkg::IRQ_SPI_DONE] = 1'b1;
            end
          end
        end
      endcase
    end

    // I2C master engine; a phase waits while a released clock line is held low.
    adv = unit && (!s_r.scl_oe_n || i2c_scl_in);
    if (s_r.mode != ssm_pkg::MODE_I2C) begin // RULE_03
      s_nxt.i2s      = ssm_pkg::I2_IDLE;
      s_nxt.scl_oe_n = 1'b1;
      s_nxt.sda_oe_n = 1'b1;
    end else begin
      unique case (s_r.i2s)
        ssm_pkg::I2_IDLE: begin
          if (s_r.cmd != 4'h0) begin
            s_nxt.i2st = 4'h0; // RULE_19
            s_nxt.tcnt = 20'h00000;
            s_nxt.ph   = 2'h0;
            s_nxt.slot = 4'h0;
            if (s_r.cmd[ssm_pkg::CMD_STOP]) begin
              s_nxt.i2s = ssm_pkg::I2_STOP;
            end else if (s_r.cmd[ssm_pkg::CMD_START]) begin
              s_nxt.i2s = ssm_pkg::I2_START;
            end else begin
              s_nxt.i2s  = ssm_pkg::I2_XFER;
              s_nxt.xmit = s_r.cmd[ssm_pkg::CMD_SEND];
              s_nxt.sh   = ld;
              tx_pop     = s_r.cmd[ssm_pkg::CMD_SEND] && !tx_empty;
            end
          end
        end
        ssm_pkg::I2_START: begin
          if (adv) begin
            s_nxt.ph = s_r.ph + 2'h1;
            case (s_r.ph)
              2'h0: s_nxt.sda_oe_n = 1'b1;
              2'h1: s_nxt.scl_oe_n = 1'b1;
              2'h2: s_nxt.sda_oe_n = 1'b0;
              default: begin
                s_nxt.scl_oe_n = 1'b0;
                s_nxt.i2s      = ssm_pkg::I2_IDLE;
                s_nxt.cmd[ssm_pkg::CMD_START] = 1'b0; // RULE_14
                s_nxt.i2st[ssm_pkg::I2_CMDFIN] = 1'b1; // RULE_19
                ev[ssm_pkg::IRQ_I2C_CMD] = 1'b1;
              end
            endcase
          end
        end
        ssm_pkg::I2_STOP: begin
          if (adv) begin
            s_nxt.ph = s_r.ph + 2'h1;
            case (s_r.ph)
              2'h0: s_nxt.sda_oe_n = 1'b0;
              2'h1: s_nxt.scl_oe_n = 1'b1;
              2'h2: s_nxt.sda_oe_n = 1'b1;
              default: begin
                s_nxt.i2s = ssm_pkg::I2_IDLE;
                s_nxt.cmd[ssm_pkg::CMD_STOP] = 1'b0; // RULE_13
                s_nxt.i2st[ssm_pkg::I2_CMDFIN] = 1'b1; // RULE_19
                ev[ssm_pkg::IRQ_I2C_CMD] = 1'b1;
              end
            endcase
          end
        end
        ssm_pkg::I2_XFER: begin
          if (adv) begin
            s_nxt.ph = s_r.ph + 2'h1;
            case (s_r.ph)
              2'h0: begin
                if (s_r.slot != ssm_pkg::ACK_SLOT) begin
                  s_nxt.sda_oe_n = !(s_r.xmit && !s_r.sh[7]);
                end else begin
                  s_nxt.sda_oe_n = s_r.xmit || !s_r.ack; // RULE_17 RULE_18
                end
              end
              2'h1: s_nxt.scl_oe_n = 1'b1;
              2'h2: begin
                if (s_r.slot != ssm_pkg::ACK_SLOT) begin
                  s_nxt.rsh = {s_r.rsh[6:0], i2c_sda_in};
                end else begin
                  s_nxt.nak_smp = i2c_sda_in;
                end
              end
              default: begin
                s_nxt.scl_oe_n = 1'b0;
                s_nxt.slot     = s_r.slot + 4'h1;
                s_nxt.sh       = {s_r.sh[6:0], 1'b0};
                if (s_r.slot == ssm_pkg::ACK_SLOT) begin
                  s_nxt.i2s = ssm_pkg::I2_IDLE;
                  if (s_r.xmit) begin
                    s_nxt.cmd[ssm_pkg::CMD_SEND] = 1'b0; // RULE_15
                    s_nxt.i2st[ssm_pkg::I2_TXFIN] = 1'b1; // RULE_19
                    s_nxt.i2st[ssm_pkg::I2_NAK] = s_r.nak_smp;
                    ev[ssm_pkg::IRQ_I2C_TX]  = 1'b1;
                    ev[ssm_pkg::IRQ_I2C_NAK] = s_r.nak_smp;
                  end else begin
                    s_nxt.cmd[ssm_pkg::CMD_RECV] = 1'b0; // RULE_16
                    s_nxt.i2st[ssm_pkg::I2_RXFIN] = 1'b1; // RULE_19
                    rx_push = 1'b1;
                    rx_byte = s_r.rsh;
                    ev[ssm_pkg::IRQ_I2C_RX] = 1'b1;
                  end
                end
              end
            endcase
          end
        end
      endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Both FIFOs; a push into a full receive FIFO with no read in the same cycle is dropped and flags an overrun.
    if (tx_push) begin
      s_nxt.txq[s_r.txwr] = wdata[7:0];
      s_nxt.txwr = s_r.txwr + PW'(1);
    end
    if (tx_pop) begin
      s_nxt.txrd = s_r.txrd + PW'(1);
    end
    s_nxt.txcnt = CW'(s_r.txcnt + CW'(tx_push) - CW'(tx_pop)); // RULE_10
    if (rx_push && rx_full && !rx_pop) begin
      ev[ssm_pkg::IRQ_SPI_OVF] = 1'b1;
      rx_push = 1'b0;
    end
    if (rx_push) begin
      s_nxt.rxq[s_r.rxwr] = rx_byte;
      s_nxt.rxwr = s_r.rxwr + PW'(1);
    end
    if (rx_pop) begin
      s_nxt.rxrd = s_r.rxrd + PW'(1);
    end
    s_nxt.rxcnt = CW'(s_r.rxcnt + CW'(rx_push) - CW'(rx_pop)); // RULE_11
    // A new overrun in the cycle of a data read keeps the flag set.
    s_nxt.ovf = (s_r.ovf && !rd_data) || ev[ssm_pkg::IRQ_SPI_OVF]; // RULE_12

    // Register writes; command bits written here win over a completion clear.
    if (wr_en) begin
      case (addr)
        ssm_pkg::MODE_OFS:     s_nxt.mode = wdata[1:0]; // RULE_03
        ssm_pkg::RATE_LIN_OFS: s_nxt.lin = wdata[3:0]; // RULE_02
        ssm_pkg::RATE_EXP_OFS: s_nxt.expo = wdata[3:0]; // RULE_01
        ssm_pkg::SPI_CFG_OFS:  s_nxt.cfg = wdata[5:0];
        ssm_pkg::I2C_CMD_OFS:  s_nxt.cmd = s_nxt.cmd | wdata[3:0];
        ssm_pkg::I2C_ACK_OFS:  s_nxt.ack = wdata[0];
        ssm_pkg::IRQ_MASK_OFS: s_nxt.irq_mask = wdata[IRQ_W-1:0];
        default: ;
      endcase
    end
    s_nxt.irq_st = s_r.irq_st | ev;
    if (wr_en && addr == ssm_pkg::IRQ_STAT_OFS) begin
      s_nxt.irq_st = (s_r.irq_st & ~wdata[IRQ_W-1:0]) | ev;
    end
    s_nxt.irq = |(s_nxt.irq_st & s_nxt.irq_mask);

    if (rd_en) begin
      case (addr)
        ssm_pkg::DATA_OFS:     rv[7:0] = rx_empty ? 8'h00 : s_r.rxq[s_r.rxrd];
        ssm_pkg::SPI_STAT_OFS: rv[3:0] = {tx_idle, !tx_full, !rx_empty, s_r.ovf}; // RULE_09
        ssm_pkg::I2C_STAT_OFS: rv[3:0] = s_r.i2st;
        ssm_pkg::I2C_CMD_OFS:  rv[3:0] = s_r.cmd;
        ssm_pkg::I2C_ACK_OFS:  rv[0] = s_r.ack;
        ssm_pkg::SPI_CFG_OFS:  rv[5:0] = s_r.cfg;
        ssm_pkg::RATE_LIN_OFS: rv[3:0] = s_r.lin;
        ssm_pkg::RATE_EXP_OFS: rv[3:0] = s_r.expo;
        ssm_pkg::MODE_OFS:     rv[1:0] = s_r.mode;
        ssm_pkg::IRQ_STAT_OFS: rv[IRQ_W-1:0] = s_r.irq_st;
        ssm_pkg::IRQ_MASK_OFS: rv[IRQ_W-1:0] = s_r.irq_mask;
        default: ;
      endcase
    end
    s_nxt.rdata = rv;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_r          <= '0;
      s_r.scl_oe_n <= 1'b1;
      s_r.sda_oe_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata        = s_r.rdata;
  assign irq          = s_r.irq;
  assign spi_sck      = s_r.sck;
  assign spi_mosi     = s_r.mosi;
  assign i2c_scl_out  = s_r.od_zero;
  assign i2c_scl_oe_n = s_r.scl_oe_n;
  assign i2c_sda_out  = s_r.od_zero;
  assign i2c_sda_oe_n = s_r.sda_oe_n;

  logic adv_stop_end;
  assign adv_stop_end = unit && s_r.ph == 2'h3 && (!s_r.scl_oe_n || i2c_scl_in);

  ////////////////////////////////////////////////////////////////////////////////
  a_rate_unit: assert property (@(posedge clk) disable iff (reset) // RULE_01
    unit |-> tick && s_r.tcnt == ((20'h00001 + 20'(s_r.lin)) << s_r.expo) - 20'h00001)
    else $error("serial half period mismatch");
  a_spi_start: assert property (@(posedge clk) disable iff (reset) // RULE_04
    s_r.mode == ssm_pkg::MODE_SPI && s_r.sst == ssm_pkg::SP_IDLE && !s_r.cfg[5] && !tx_empty
    |=> s_r.sst == ssm_pkg::SP_RUN
        && s_r.txcnt == $past(s_r.txcnt) - CW'(1) + CW'($past(wr_data && !tx_full)))
    else $error("spi did not start on transmit data");
  a_txidle_read: assert property (@(posedge clk) disable iff (reset) // RULE_09
    rd_en && addr == ssm_pkg::SPI_STAT_OFS |=> rdata[3] == $past(tx_empty && s_r.sst == ssm_pkg::SP_IDLE))
    else $error("transmitter idle flag wrong");
  a_txfree_read: assert property (@(posedge clk) disable iff (reset) // RULE_10
    rd_en && addr == ssm_pkg::SPI_STAT_OFS |=> rdata[2] == ($past(s_r.txcnt) < FULL))
    else $error("transmit space flag wrong");
  a_rxval_read: assert property (@(posedge clk) disable iff (reset) // RULE_11
    rd_en && addr == ssm_pkg::SPI_STAT_OFS |=> rdata[1] == ($past(s_r.rxcnt) != '0))
    else $error("receive valid flag wrong");
  a_ovf_clear: assert property (@(posedge clk) disable iff (reset) // RULE_12
    rd_data && !s_nxt.irq_st[0] |=> !s_r.ovf ##1 !s_r.ovf || s_r.irq_st[0])
    else $error("overrun not cleared by data read");
  a_stop_done: assert property (@(posedge clk) disable iff (reset) // RULE_13
    s_r.i2s == ssm_pkg::I2_STOP && adv_stop_end |=> !s_r.cmd[3] || $past(wr_en) ##0 s_r.i2st[3])
    else $error("stop command not completed");
  a_start_done: assert property (@(posedge clk) disable iff (reset) // RULE_14
    $fell(s_r.cmd[2]) && !$past(wr_en) |-> $past(s_r.i2s) == ssm_pkg::I2_START && s_r.i2st[3])
    else $error("start bit cleared outside start");
  a_send_done: assert property (@(posedge clk) disable iff (reset) // RULE_15
    $fell(s_r.cmd[1]) |-> $past(s_r.slot) == ssm_pkg::ACK_SLOT && s_r.i2st[1])
    else $error("send bit cleared early");
  a_ack_drive: assert property (@(posedge clk) disable iff (reset) // RULE_17
    s_r.i2s == ssm_pkg::I2_XFER && !s_r.xmit && s_r.slot == ssm_pkg::ACK_SLOT && s_r.ph == 2'h2
    |-> s_r.sda_oe_n == !s_r.ack)
    else $error("ack reply level wrong");
endmodule

// File: logic/ssm_pkg.sv
// Shared constants and types for the serial SPI/I2C master controller.
package ssm_pkg;
  localparam logic [15:0] DATA_OFS     = 16'h449E;
  localparam logic [15:0] SPI_STAT_OFS = 16'h44A0;
  localparam logic [15:0] I2C_STAT_OFS = 16'h44A2;
  localparam logic [15:0] I2C_CMD_OFS  = 16'h44A6;
  localparam logic [15:0] I2C_ACK_OFS  = 16'h44A8;
  localparam logic [15:0] SPI_CFG_OFS  = 16'h44AC;
  localparam logic [15:0] RATE_LIN_OFS = 16'h44B0;
  localparam logic [15:0] RATE_EXP_OFS = 16'h44B2;
  localparam logic [15:0] MODE_OFS     = 16'h44BA;
  localparam logic [15:0] IRQ_STAT_OFS = 16'h44C0;
  localparam logic [15:0] IRQ_MASK_OFS = 16'h44C2;
  localparam logic [15:0] REG_RESET    = 16'h0000;

  localparam logic [1:0] MODE_OFF  = 2'h0;
  localparam logic [1:0] MODE_UART = 2'h1;
  localparam logic [1:0] MODE_SPI  = 2'h2;
  localparam logic [1:0] MODE_I2C  = 2'h3;

  localparam int CFG_RXPACED = 5;
  localparam int CFG_ROLE    = 4;
  localparam int CFG_RPT     = 3;
  localparam int CFG_ORD     = 2;
  localparam int CFG_PHA     = 1;
  localparam int CFG_POL     = 0;
  localparam int ST_TXIDLE   = 3;
  localparam int ST_TXFREE   = 2;
  localparam int ST_RXVAL    = 1;
  localparam int ST_RXOVF    = 0;
  localparam int CMD_STOP    = 3;
  localparam int CMD_START   = 2;
  localparam int CMD_SEND    = 1;
  localparam int CMD_RECV    = 0;
  localparam int I2_CMDFIN   = 3;
  localparam int I2_RXFIN    = 2;
  localparam int I2_TXFIN    = 1;
  localparam int I2_NAK      = 0;
  localparam int IRQ_SPI_OVF = 0;
  localparam int IRQ_SPI_DONE = 1;
  localparam int IRQ_I2C_CMD = 2;
  localparam int IRQ_I2C_RX  = 3;
  localparam int IRQ_I2C_TX  = 4;
  localparam int IRQ_I2C_NAK = 5;
  localparam int IRQ_W       = 6;

  localparam int REF_MHZ = 24;
  localparam int CLK_MHZ = 100;
  localparam logic [6:0] REF_INC = 7'(REF_MHZ);
  localparam logic [6:0] REF_MOD = 7'(CLK_MHZ);
  localparam logic [7:0] BUSY_TOKEN = 8'hFF;
  localparam logic [3:0] LAST_HALF = 4'hF;
  localparam logic [3:0] ACK_SLOT  = 4'h8;

  typedef enum logic {SP_IDLE, SP_RUN} ssm_spi_t;
  typedef enum logic [1:0] {I2_IDLE, I2_START, I2_STOP, I2_XFER} ssm_i2c_t;
endpackage

// File: dv/ssm_slave.sv
// Behavioural SPI and I2C slave facing the serial controller.
`timescale 1ns/1ps
module ssm_slave (
  input  wire logic       clk,
  input  wire logic       clr,
  input  wire logic       pol,
  input  wire logic       pha,
  input  wire logic       sck,
  input  wire logic       mosi,
  output logic            miso,
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       ack_en,
  output logic            sda_pull,
  output logic      [7:0] last_byte,
  output int              n_bytes
);
  logic       sck_q = 1'b0;
  logic       scl_q = 1'b1;
  logic       sda_q = 1'b1;
  logic [7:0] sh = 8'h00;
  logic [2:0] nb = 3'h0;
  logic [3:0] cnt = 4'h0;
  ////////////////////////////////////////////////////////////
  // Echo keeps the returned byte equal to the sent one in every mode.
  assign miso = mosi;
  assign sda_pull = ack_en && cnt == 4'h8;
  initial {last_byte, n_bytes} = '0;
  always @(posedge clk) begin
    sck_q <= sck;
    scl_q <= scl;
    sda_q <= sda;
    if (clr) begin
      nb <= 3'h0;
    end else if (sck != sck_q && (sck ^ pol ^ pha)) begin
      sh <= {sh[6:0], mosi};
      nb <= nb + 3'h1;
      if (nb == 3'h7) begin
        last_byte <= {sh[6:0], mosi};
        n_bytes <= n_bytes + 1;
      end
    end
    if (scl && scl_q && sda_q && !sda) begin
      cnt <= 4'hF;
    end else if (scl_q && !scl) begin
      cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
    end
  end
endmodule

// File: dv/serial_spi_i2c_master_ctrl_tb.sv
// Self-checking bench for the serial SPI/I2C master controller.
`timescale 1ns/1ps
module serial_spi_i2c_master_ctrl_tb;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic        clr = 1'b0;
  logic        ack_en = 1'b0;
  logic        rx_mon = 1'b0;
  logic        pulled = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] cfg = 16'h0000;
  logic [15:0] rdata;
  logic [7:0]  slv_byte;
  logic        irq, sck, mosi, miso, scl_oe_n, sda_oe_n, sda_pull, sda_w;
  int          slv_n;
  int          n_errors = 0;
  int          tests_run = 0;
  logic [15:0] ofs [6] = '{ssm_pkg::I2C_CMD_OFS, ssm_pkg::I2C_ACK_OFS, ssm_pkg::SPI_CFG_OFS,
                           ssm_pkg::RATE_EXP_OFS, ssm_pkg::MODE_OFS, 16'h44FE};
  assign sda_w = sda_oe_n & ~sda_pull;
  always #5 clk = ~clk;
  ssm_ctrl #(.DEPTH(4)) dut (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .irq(irq), .spi_sck(sck), .spi_mosi(mosi),
    .spi_miso(miso), .i2c_scl_in(scl_oe_n), .i2c_scl_out(), .i2c_scl_oe_n(scl_oe_n),
    .i2c_sda_in(sda_w), .i2c_sda_out(), .i2c_sda_oe_n(sda_oe_n));
  ssm_slave slv (
    .clk(clk), .clr(clr), .pol(cfg[0]), .pha(cfg[1]), .sck(sck), .mosi(mosi),
    .miso(miso), .scl(scl_oe_n), .sda(sda_w), .ack_en(ack_en), .sda_pull(sda_pull),
    .last_byte(slv_byte), .n_bytes(slv_n));
  // A pull of the data line while the clock is high, during a receive, is the ack slot.
  always @(posedge clk) pulled <= rx_mon && (pulled || (!sda_oe_n && scl_oe_n));
  ////////////////////////////////////////////////////////////
  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int k = 0; k < 8; k++) rev8[k] = v[7 - k];
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic poll(input logic [15:0] a, input logic [15:0] m, input logic [15:0] v);
    logic [15:0] d;
    for (int k = 0; k < 3000; k++) begin
      rd(a, d);
      if ((d & m) === v) break;
    end
    chk("poll", v, d & m);
  endtask
  task automatic cmd(input logic [3:0] c, input logic [15:0] e);
    logic [15:0] d;
    wr(ssm_pkg::I2C_CMD_OFS, 16'(c));
    poll(ssm_pkg::I2C_CMD_OFS, 16'h000F, 16'h0000);
    rd(ssm_pkg::I2C_STAT_OFS, d);
    chk("i2c status", e, d);
  endtask
  task automatic wait_bytes(input int n);
    for (int k = 0; k < 4000 && slv_n < n; k++) @(posedge clk);
    chk("slave bytes", 16'(n), 16'(slv_n));
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    wrap_up();
  end
  initial begin
    logic [15:0] d;
    logic [7:0]  b [5];
    int          t, n;
    logic        s;
    n = $urandom(13);
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    foreach (ofs[j]) begin
      rd(ofs[j], d);
      chk("reset value", ssm_pkg::REG_RESET, d);
    end
    wr(16'h44FE, 16'hFFFF);
    rd(16'h44FE, d);
    chk("unmapped", 16'h0000, d);
    for (int i = 0; i < 8; i++) begin
      b[0] = 8'($urandom_range(255));
      wr(ssm_pkg::MODE_OFS, 16'h0000);
      cfg = 16'h0010 | 16'(i);
      wr(ssm_pkg::SPI_CFG_OFS, cfg);
      wr(ssm_pkg::MODE_OFS, 16'h0002);
      repeat (3) @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      chk("sck idle", 16'(cfg[0]), 16'(sck));
      wr(ssm_pkg::DATA_OFS, 16'(b[0]));
      poll(ssm_pkg::SPI_STAT_OFS, 16'h000A, 16'h000A);
      chk("wire byte", 16'(cfg[2] ? rev8(b[0]) : b[0]), 16'(slv_byte));
      rd(ssm_pkg::DATA_OFS, d);
      chk("echo byte", 16'(b[0]), d);
    end
    chk("masked irq", 16'h0000, 16'(irq));
    rd(ssm_pkg::IRQ_STAT_OFS, d);
    chk("irq status", 16'h0002, d);
    wr(ssm_pkg::IRQ_MASK_OFS, 16'h0002);
    repeat (2) @(posedge clk);
    chk("irq on", 16'h0001, 16'(irq));
    wr(ssm_pkg::IRQ_STAT_OFS, 16'h0002);
    repeat (2) @(posedge clk);
    chk("irq off", 16'h0000, 16'(irq));
    for (int i = 0; i < 5; i++) begin
      b[i] = 8'($urandom_range(255));
      wr(ssm_pkg::DATA_OFS, 16'(b[i]));
      if (i > 2) poll(ssm_pkg::SPI_STAT_OFS, 16'h0008, 16'h0008);
    end
    rd(ssm_pkg::SPI_STAT_OFS, d);
    chk("overrun status", 16'h000F, d);
    wr(ssm_pkg::IRQ_STAT_OFS, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      rd(ssm_pkg::DATA_OFS, d);
      chk("rx byte", 16'(b[i]), d);
      rd(ssm_pkg::SPI_STAT_OFS, d);
      chk("status after read", i < 3 ? 16'h000E : 16'h000C, d);
    end
    wr(ssm_pkg::MODE_OFS, 16'h0000);
    cfg = 16'h0018;
    wr(ssm_pkg::SPI_CFG_OFS, cfg);
    wr(ssm_pkg::RATE_LIN_OFS, 16'h0001);
    wr(ssm_pkg::RATE_EXP_OFS, 16'h0002);
    wr(ssm_pkg::MODE_OFS, 16'h0002);
    b[0] = 8'($urandom_range(255));
    wr(ssm_pkg::DATA_OFS, 16'(b[0]));
    t = 0;
    for (int k = 0; k < 16; k++) begin
      s = sck;
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (sck === s && n < 200);
      if (k > 0) t += n;
    end
    chk("byte span", (t >= 499 && t <= 501) ? 16'(t) : 16'h01F4, 16'(t));
    poll(ssm_pkg::SPI_STAT_OFS, 16'h000A, 16'h000A);
    rd(ssm_pkg::DATA_OFS, d);
    wr(ssm_pkg::RATE_LIN_OFS, 16'h0000);
    wr(ssm_pkg::RATE_EXP_OFS, 16'h0000);
    n = slv_n + 4;
    cfg = 16'h0038;
    wr(ssm_pkg::SPI_CFG_OFS, cfg);
    wait_bytes(n);
    chk("repeat byte", 16'(b[0]), 16'(slv_byte));
    cfg = 16'h0030;
    wr(ssm_pkg::SPI_CFG_OFS, cfg);
    for (int i = 0; i < 4; i++) begin
      rd(ssm_pkg::DATA_OFS, d);
      chk("repeat echo", 16'(b[0]), d);
    end
    wait_bytes(n + 4);
    chk("busy token", 16'(ssm_pkg::BUSY_TOKEN), 16'(slv_byte));
    wr(ssm_pkg::MODE_OFS, 16'h0000);
    wr(ssm_pkg::MODE_OFS, 16'h0003);
    wr(ssm_pkg::IRQ_STAT_OFS, 16'h003F);
    wr(ssm_pkg::IRQ_MASK_OFS, 16'h0004);
    cmd(4'h4, 16'h0008);
    chk("command irq", 16'h0001, 16'(irq));
    ack_en <= 1'b1;
    wr(ssm_pkg::DATA_OFS, 16'($urandom_range(255)));
    cmd(4'h2, 16'h0002);
    ack_en <= 1'b0;
    wr(ssm_pkg::DATA_OFS, 16'($urandom_range(255)));
    cmd(4'h2, 16'h0003);
    for (int i = 0; i < 2; i++) begin
      wr(ssm_pkg::I2C_ACK_OFS, 16'(1 - i));
      rx_mon <= 1'b1;
      cmd(4'h1, 16'h0004);
      chk("ack drive", 16'(1 - i), 16'(pulled));
      rx_mon <= 1'b0;
    end
    cmd(4'h4, 16'h0008);
    cmd(4'h8, 16'h0008);
    chk("lines released", 16'h0003, 16'({scl_oe_n, sda_oe_n}));
    wrap_up();
  end
endmodule
